// ### hw/rpsc_core.sv
// packet-level control and status of the radio: mode pins, coding, status outputs
// assumes pins synchronous to pclk and a demodulator giving chips with strobes
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rpsc_defs.svh"
module rpsc_core #(
    parameter int CHIP_CYC  = `RPSC_CHIP_CYC,
    parameter int PRE_CHIPS = `RPSC_PRE_CHIPS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        power_on_in,
    input  wire logic        radio_activate,
    input  wire logic        tx_select_pin,
    input  wire logic        rf_carrier_in,
    input  wire logic        rx_sync_in,
    input  wire logic        rx_chip_vld_in,
    input  wire logic        rx_chip_in,
    input  wire logic        rx_end_in,
    input  wire logic        rx_crc_ok_in,
    output logic             tx_chip_out,
    output logic             tx_on_out,
    output logic [7:0]       pa_dbm_out,
    output logic [13:0]      tune_word_out,
    output logic             rx_low_power_out,
    output logic             carrier_sense_out,
    output logic             addr_match_out,
    output logic             packet_done_out
);
    rpsc_pkg::rpsc_mode_t mode_q, mode_d;
    logic [31:0] ctrl_q, ctrl_d, txdat_q, txdat_d, rxadr_q, rxadr_d;
    logic [31:0] sh_q, sh_d, rxbuf_q, rxbuf_d;
    logic [11:0] ccnt_q, ccnt_d;
    logic [5:0]  idx_q, idx_d;
    logic [6:0]  rcnt_q, rcnt_d;
    logic        act_q, act_d, half_q, half_d, first_q, first_d;
    logic        am_q, am_d, dr_q, dr_d, cs_q, cs_d, ra_q, ts_q;
    logic        chip_q, chip_d;
    logic [7:0]  dbm_q, dbm_d;
    logic [13:0] tune_q, tune_d;
    logic        wr, rd, tick, auto, in_tx, rx_ok, bit_v;
    logic [31:0] nsh;

    assign wr   = psel && penable && pwrite;
    assign rd   = psel && penable && !pwrite;
    assign auto = ctrl_q[`RPSC_F_AUTO];
    assign in_tx = (mode_q == rpsc_pkg::RPSC_TXPRE) || (mode_q == rpsc_pkg::RPSC_TXDAT);
    assign tick = in_tx && (ccnt_q == 12'(CHIP_CYC - 1));
    assign rx_ok = am_q && (rcnt_q == 7'h40) && rx_crc_ok_in;
    assign bit_v = txdat_q[~idx_q[5:1]];
    assign nsh  = {sh_q[30:0], first_q};
    // zero-wait slave
    assign pready = 1'b1;

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            `RPSC_ADR_CTRL:  prdata = ctrl_q;
            `RPSC_ADR_STAT:  prdata = {24'h000000, am_q, 1'b0, dr_q, 5'h00};
            `RPSC_ADR_TXDAT: prdata = txdat_q;
            `RPSC_ADR_RXADR: prdata = rxadr_q;
            `RPSC_ADR_RXDAT: prdata = rxbuf_q;
            `RPSC_ADR_FREQ:  prdata = {18'h00000, tune_q};
            default:         pslverr = psel && penable;
        endcase
    end

    always_comb begin
        ctrl_d  = ctrl_q;
        txdat_d = txdat_q;
        rxadr_d = rxadr_q;
        if (wr && paddr == `RPSC_ADR_CTRL) begin
            ctrl_d = pwdata;
        end
        if (wr && paddr == `RPSC_ADR_TXDAT) begin
            txdat_d = pwdata;
        end
        if (wr && paddr == `RPSC_ADR_RXADR) begin
            rxadr_d = pwdata;
        end
        unique case (ctrl_q[1:0])
            2'h0: dbm_d = `RPSC_DBM_M10;
            2'h1: dbm_d = `RPSC_DBM_M2;
            2'h2: dbm_d = `RPSC_DBM_P6;
            2'h3: dbm_d = `RPSC_DBM_P10;
        endcase
        // units of 100 kHz; doubling the band doubles the step
        tune_d = (`RPSC_FBASE + 14'(ctrl_q[16:8])) << ctrl_q[`RPSC_F_BAND];
    end

    always_comb begin
        mode_d = mode_q;
        ccnt_d = tick ? 12'h000 : ccnt_q + 12'h001;
        idx_d  = tick ? idx_q + 6'h01 : idx_q;
        unique case (mode_q)
            rpsc_pkg::RPSC_OFF: begin
                if (power_on_in) mode_d = rpsc_pkg::RPSC_STBY;
            end
            rpsc_pkg::RPSC_STBY: begin
                if (radio_activate && !ra_q && tx_select_pin) begin
                    mode_d = rpsc_pkg::RPSC_TXPRE;
                end else if (radio_activate && !tx_select_pin) begin
                    mode_d = rpsc_pkg::RPSC_RX;
                end
            end
            rpsc_pkg::RPSC_RX: begin
                if (!radio_activate) begin
                    mode_d = rpsc_pkg::RPSC_STBY;
                end else if (tx_select_pin) begin
                    mode_d = rpsc_pkg::RPSC_TXPRE;
                end
            end
            rpsc_pkg::RPSC_TXPRE: begin
                if (tick && idx_q == 6'(PRE_CHIPS - 1)) begin
                    mode_d = rpsc_pkg::RPSC_TXDAT;
                    idx_d  = 6'h00;
                end
            end
            rpsc_pkg::RPSC_TXDAT: begin
                // activate is only looked at on the last chip
                if (tick && idx_q == 6'h3F) begin
                    if (auto && radio_activate && tx_select_pin) begin
                        mode_d = rpsc_pkg::RPSC_TXPRE;
                    end else begin
                        mode_d = rpsc_pkg::RPSC_STBY;
                    end
                end
            end
            default: mode_d = rpsc_pkg::RPSC_OFF;
        endcase
        if (!in_tx) begin
            ccnt_d = 12'h000;
            idx_d  = 6'h00;
        end
        if (!power_on_in) mode_d = rpsc_pkg::RPSC_OFF;
        // preamble alternates; data bit 1 sends 1 then 0
        if (mode_q == rpsc_pkg::RPSC_TXPRE) begin
            chip_d = ~idx_q[0];
        end else if (mode_q == rpsc_pkg::RPSC_TXDAT) begin
            chip_d = bit_v ^ idx_q[0];
        end else begin
            chip_d = 1'b0;
        end
    end

    always_comb begin
        act_d   = act_q;
        half_d  = half_q;
        first_d = first_q;
        rcnt_d  = rcnt_q;
        sh_d    = sh_q;
        rxbuf_d = rxbuf_q;
        am_d    = am_q;
        dr_d    = dr_q;
        cs_d    = (mode_q == rpsc_pkg::RPSC_RX) && rf_carrier_in;
        // clears first so that sets in the same cycle win
        if (rd && paddr == `RPSC_ADR_RXDAT) begin
            dr_d = 1'b0;
            am_d = 1'b0;
        end
        if (mode_q == rpsc_pkg::RPSC_RX && rx_sync_in) begin
            act_d  = 1'b1;
            half_d = 1'b0;
            rcnt_d = 7'h00;
        end else if (mode_q == rpsc_pkg::RPSC_RX && act_q && rx_chip_vld_in) begin
            if (!half_q) begin
                first_d = rx_chip_in;
                half_d  = 1'b1;
            end else begin
                half_d = 1'b0;
                // equal chips are a coding violation
                if (first_q == rx_chip_in || rcnt_q == 7'h40) begin
                    act_d  = 1'b0;
                    rcnt_d = 7'h7F;
                end else begin
                    sh_d   = nsh;
                    rcnt_d = rcnt_q + 7'h01;
                    if (rcnt_q == 7'h1F) begin
                        if (nsh == rxadr_q) am_d = 1'b1;
                        else act_d = 1'b0;
                    end
                end
            end
        end
        if (mode_d == rpsc_pkg::RPSC_TXPRE && mode_q != rpsc_pkg::RPSC_TXPRE) dr_d = 1'b0;
        if (mode_d == rpsc_pkg::RPSC_RX && mode_q != rpsc_pkg::RPSC_RX) dr_d = 1'b0;
        if (!tx_select_pin && ts_q && mode_q != rpsc_pkg::RPSC_RX) dr_d = 1'b0;
        if (auto && mode_q == rpsc_pkg::RPSC_TXPRE && mode_d == rpsc_pkg::RPSC_TXDAT) dr_d = 1'b0;
        if (mode_q == rpsc_pkg::RPSC_RX && rx_end_in) begin
            act_d = 1'b0;
            if (rx_ok) begin
                dr_d    = 1'b1;
                rxbuf_d = sh_q;
            end else begin
                am_d = 1'b0;
            end
        end
        if (mode_q == rpsc_pkg::RPSC_TXDAT && mode_d == rpsc_pkg::RPSC_STBY && !auto) dr_d = 1'b1;
        if (auto && mode_d == rpsc_pkg::RPSC_TXPRE) dr_d = 1'b1;
        if (mode_d != rpsc_pkg::RPSC_RX) begin
            am_d  = 1'b0;
            act_d = 1'b0;
        end
        if (!power_on_in || tx_select_pin) begin
            rxbuf_d = 32'h0000_0000;
            am_d    = 1'b0;
            if (mode_q == rpsc_pkg::RPSC_RX || !power_on_in) dr_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= rpsc_pkg::RPSC_OFF;
            ctrl_q  <= `RPSC_CTRL_RST;
            txdat_q <= 32'h0000_0000;
            rxadr_q <= `RPSC_RXADR_RST;
            sh_q    <= 32'h0000_0000;
            rxbuf_q <= 32'h0000_0000;
            ccnt_q  <= 12'h000;
            idx_q   <= 6'h00;
            rcnt_q  <= 7'h00;
            act_q   <= 1'b0;
            half_q  <= 1'b0;
            first_q <= 1'b0;
            am_q    <= 1'b0;
            dr_q    <= 1'b0;
            cs_q    <= 1'b0;
            ra_q    <= 1'b0;
            ts_q    <= 1'b0;
            chip_q  <= 1'b0;
            dbm_q   <= `RPSC_DBM_M10;
            tune_q  <= `RPSC_FBASE;
        end else begin
            mode_q  <= mode_d;
            ctrl_q  <= ctrl_d;
            txdat_q <= txdat_d;
            rxadr_q <= rxadr_d;
            sh_q    <= sh_d;
            rxbuf_q <= rxbuf_d;
            ccnt_q  <= ccnt_d;
            idx_q   <= idx_d;
            rcnt_q  <= rcnt_d;
            act_q   <= act_d;
            half_q  <= half_d;
            first_q <= first_d;
            am_q    <= am_d;
            dr_q    <= dr_d;
            cs_q    <= cs_d;
            ra_q    <= radio_activate;
            ts_q    <= tx_select_pin;
            chip_q  <= chip_d;
            dbm_q   <= dbm_d;
            tune_q  <= tune_d;
        end
    end

    assign tx_chip_out       = chip_q;
    assign tx_on_out         = in_tx;
    assign pa_dbm_out        = dbm_q;
    assign tune_word_out     = tune_q;
    assign rx_low_power_out  = ctrl_q[`RPSC_F_LOWRX];
    assign carrier_sense_out = cs_q;
    assign addr_match_out    = am_q;
    assign packet_done_out   = dr_q;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pa_level: assert property ($past(ctrl_q[1:0]) == 2'h3 |-> pa_dbm_out == 8'h0A)
        else $error("pa level wrong");
    a_tune_map: assert property (##1 tune_word_out == 14'((14'd4224 + 14'($past(ctrl_q[16:8])))
        * (14'd1 + 14'($past(ctrl_q[3])))))
        else $error("tune word wrong");
    a_tune_step: assert property ($past(ctrl_q[3]) |-> !tune_word_out[0])
        else $error("doubled step odd");
    a_chip_hold: assert property (in_tx && !tick && $past(in_tx) && !$past(tick) |=> $stable(tx_chip_out))
        else $error("chip moved early");
    a_cs_gate: assert property (mode_q != rpsc_pkg::RPSC_RX |=> !carrier_sense_out)
        else $error("sense outside receive");
    a_am_drop: assert property (mode_q == rpsc_pkg::RPSC_RX && rx_end_in && !rx_ok |=> !addr_match_out)
        else $error("match not dropped");
    a_dr_valid: assert property ($rose(packet_done_out) && $past(mode_q) == rpsc_pkg::RPSC_RX
        |-> $past(rx_end_in && rx_crc_ok_in))
        else $error("ready without good packet");
    a_dr_sent: assert property (mode_q == rpsc_pkg::RPSC_TXDAT && mode_d == rpsc_pkg::RPSC_STBY && !auto
        |=> packet_done_out && mode_q == rpsc_pkg::RPSC_STBY)
        else $error("no ready after send");
    a_dr_pre: assert property (auto && mode_q == rpsc_pkg::RPSC_TXDAT |-> !packet_done_out)
        else $error("ready past preamble");
    a_resend: assert property (mode_q == rpsc_pkg::RPSC_TXDAT && tick && idx_q == 6'h3F && auto
        && radio_activate && tx_select_pin && power_on_in |=> mode_q == rpsc_pkg::RPSC_TXPRE && packet_done_out)
        else $error("resend missing");
    a_finish: assert property (mode_q == rpsc_pkg::RPSC_TXDAT && !tick && power_on_in
        |=> mode_q == rpsc_pkg::RPSC_TXDAT)
        else $error("packet cut short");
    a_pwr_clr: assert property (!power_on_in |=> !packet_done_out && !addr_match_out && rxbuf_q == 32'h0)
        else $error("power-off left state");

    c_rx_good: cover property (mode_q == rpsc_pkg::RPSC_RX && rx_end_in && rx_ok);
    c_tx_done: cover property ($rose(packet_done_out) && mode_q == rpsc_pkg::RPSC_STBY);
    c_resend:  cover property (auto && mode_q == rpsc_pkg::RPSC_TXDAT ##1 mode_q == rpsc_pkg::RPSC_TXPRE);
endmodule

// ### include/rpsc_defs.svh
// constants for the packet status/control block: offsets, fields, resets, timing
// assumes a 250 MHz pclk and a byte-addressed 32-bit APB slave port
// Overview of operation
// - two-bit field picks transmit amplifier level
// - Manchester coding both ways, 100 kbps chips
// - tune word is (4224+channel) doubled by band
// - channel step 100 kHz, or 200 kHz doubled
// - carrier-sense follows carrier while receiving
// - address-match rises on own identity match
// - failed packet drops address-match at end
// - single transmit done raises data-ready
// - single transmit start or mode change clears data-ready
// - resend pulses data-ready across each preamble
// - receive data-ready needs address, length, CRC
// - payload read or transmit clears receive data-ready
// - resend repeats packet while activate and select
// - activate low finishes packet, then standby
// - selectable reduced-power receive setting
// - power-off or transmit select clears receive state
// - single transmit ends in standby awaiting pulse
// - status byte: match bit 7, ready bit 5
`ifndef RPSC_DEFS_SVH
`define RPSC_DEFS_SVH
`define RPSC_CLK_NS      4
`define RPSC_CHIP_NS     10000
`define RPSC_CHIP_CYC    (`RPSC_CHIP_NS / `RPSC_CLK_NS)
`define RPSC_PRE_CHIPS   20
`define RPSC_ADR_CTRL    8'h00
`define RPSC_ADR_STAT    8'h04
`define RPSC_ADR_TXDAT   8'h08
`define RPSC_ADR_RXADR   8'h0C
`define RPSC_ADR_RXDAT   8'h10
`define RPSC_ADR_FREQ    8'h14
`define RPSC_CTRL_RST    32'h0000_0000
`define RPSC_RXADR_RST   32'hE7E7_E7E7
`define RPSC_F_AUTO      2
`define RPSC_F_BAND      3
`define RPSC_F_LOWRX     4
`define RPSC_F_CH_LO     8
`define RPSC_ST_AM       7
`define RPSC_ST_DR       5
`define RPSC_FBASE       14'h1080
`define RPSC_DBM_M10     8'hF6
`define RPSC_DBM_M2      8'hFE
`define RPSC_DBM_P6      8'h06
`define RPSC_DBM_P10     8'h0A
`endif

// ### include/rpsc_pkg.sv
// types of the packet status/control block
// assumes nothing beyond a SystemVerilog compiler
package rpsc_pkg;
    typedef enum logic [2:0] {
        RPSC_OFF   = 3'h0,
        RPSC_STBY  = 3'h1,
        RPSC_RX    = 3'h2,
        RPSC_TXPRE = 3'h3,
        RPSC_TXDAT = 3'h4
    } rpsc_mode_t;
endpackage

// ### tb/rpsc_air_model.sv
// air-side model: carrier level, sync pulse, chip strobes, end with crc flag
// assumes its tasks are called just after a rising pclk edge
`timescale 1ns/1ps
module rpsc_air_model (
    input  wire logic pclk,
    output logic      rf_carrier_in,
    output logic      rx_sync_in,
    output logic      rx_chip_vld_in,
    output logic      rx_chip_in,
    output logic      rx_end_in,
    output logic      rx_crc_ok_in
);
    initial begin
        {rf_carrier_in, rx_sync_in, rx_chip_vld_in} = 3'h0;
        {rx_chip_in, rx_end_in, rx_crc_ok_in} = 3'h0;
    end
    task automatic carrier(input logic v);
        rf_carrier_in <= v;
    endtask
    // 64 bits msb first, each bit a chip pair: 1 -> 1,0 and 0 -> 0,1
    task automatic send(input logic [63:0] b, input logic ok);
        logic c;
        rx_sync_in <= 1'b1;
        @(posedge pclk);
        rx_sync_in <= 1'b0;
        for (int i = 127; i >= 0; i--) begin
            c = b[i / 2] ^ ~i[0];
            rx_chip_vld_in <= 1'b1;
            rx_chip_in     <= c;
            @(posedge pclk);
            rx_chip_vld_in <= 1'b0;
            // idle chip line shows the inverse, so a held value is never mistaken
            rx_chip_in     <= ~c;
            @(posedge pclk);
        end
        rx_end_in    <= 1'b1;
        rx_crc_ok_in <= ok;
        @(posedge pclk);
        rx_end_in    <= 1'b0;
        rx_crc_ok_in <= ~ok;
    endtask
endmodule

// ### tb/test_rpsc_core.sv
// self-checking bench for the packet status/control core with an air model
// assumes 250 MHz pclk and shortened chip and preamble counts
`timescale 1ns/1ps
`include "rpsc_defs.svh"
module test_rpsc_core;
    localparam int          CC  = 4;
    localparam int          PC  = 4;
    localparam logic [31:0] PAY = 32'h3C69_D21B;
    localparam logic [31:0] TXD = 32'hA5C3_0F96;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0]  dbm;
        logic [13:0] tune;
    } rpsc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, pa_dbm_out;
    logic [31:0] pwdata, prdata, r;
    logic        power_on_in, radio_activate, tx_select_pin, rf_carrier_in;
    logic        rx_sync_in, rx_chip_vld_in, rx_chip_in, rx_end_in, rx_crc_ok_in;
    logic        tx_chip_out, tx_on_out, rx_low_power_out;
    logic        carrier_sense_out, addr_match_out, packet_done_out, e, x;
    logic [13:0] tune_word_out;
    int          fail_count, checks_done, pulses;
    rpsc_row_t   rows [4];
    rpsc_core #(.CHIP_CYC(CC), .PRE_CHIPS(PC)) rpsc_core_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
        .prdata, .pslverr, .power_on_in, .radio_activate, .tx_select_pin,
        .rf_carrier_in, .rx_sync_in, .rx_chip_vld_in, .rx_chip_in, .rx_end_in,
        .rx_crc_ok_in, .tx_chip_out, .tx_on_out, .pa_dbm_out, .tune_word_out,
        .rx_low_power_out, .carrier_sense_out, .addr_match_out, .packet_done_out);
    rpsc_air_model rpsc_air_model_inst (
        .pclk, .rf_carrier_in, .rx_sync_in, .rx_chip_vld_in, .rx_chip_in,
        .rx_end_in, .rx_crc_ok_in);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        results();
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] g);
        checks_done++;
        if (g !== xp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, xp, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] xp, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, xp, r);
    endtask
    task automatic wait_tx(input logic v);
        int n;
        n = 0;
        while (tx_on_out !== v && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk("tx_on", v, tx_on_out);
    endtask
    task automatic rx_pkt(input logic [31:0] a, input logic ok, input logic am);
        fork
            rpsc_air_model_inst.send({a, PAY}, ok);
            begin
                cyc(160);
                chk("match", am, addr_match_out);
                chk("ready", 1'b0, packet_done_out);
            end
        join
        cyc(2);
    endtask
    initial begin
        rows[0] = '{32'h0000_6B10, 8'hF6, 14'h10EB};
        rows[1] = '{32'h0000_7509, 8'hFE, 14'h21EA};
        rows[2] = '{32'h0001_1F0A, 8'h06, 14'h233E};
        rows[3] = '{32'h0001_FF03, 8'h0A, 14'h127F};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, radio_activate, tx_select_pin, x} = 4'h0;
        power_on_in = 1'b1;
        fail_count = 0;
        checks_done = 0;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
        chk("pa_dbm", 8'hF6, pa_dbm_out);
        rd(`RPSC_ADR_CTRL, `RPSC_CTRL_RST, "ctrl");
        rd(`RPSC_ADR_RXADR, `RPSC_RXADR_RST, "rxaddr");
        rd(`RPSC_ADR_FREQ, 32'h0000_1080, "freq");
        rd(8'h18, 32'h0, "unmapped");
        chk("pslverr", 1'b1, e);
        apb(1'b1, `RPSC_ADR_STAT, 32'hFFFF_FFFF);
        rd(`RPSC_ADR_STAT, 32'h0, "status");
        foreach (rows[i]) begin
            apb(1'b1, `RPSC_ADR_CTRL, rows[i].ctrl);
            cyc(2);
            chk("pa_dbm", rows[i].dbm, pa_dbm_out);
            chk("tune", rows[i].tune, tune_word_out);
            chk("low_rx", rows[i].ctrl[`RPSC_F_LOWRX], rx_low_power_out);
            rd(`RPSC_ADR_FREQ, {18'h0, rows[i].tune}, "freq");
        end
        apb(1'b1, `RPSC_ADR_CTRL, 32'h0);
        apb(1'b1, `RPSC_ADR_TXDAT, TXD);
        radio_activate <= 1'b1;
        cyc(3);
        chk("carrier", 1'b0, carrier_sense_out);
        rpsc_air_model_inst.carrier(1'b1);
        cyc(2);
        chk("carrier", 1'b1, carrier_sense_out);
        rx_pkt(32'hE7E7_E7E7, 1'b1, 1'b1);
        chk("ready", 1'b1, packet_done_out);
        rd(`RPSC_ADR_STAT, 32'h0000_00A0, "status");
        rd(`RPSC_ADR_RXDAT, PAY, "rxdata");
        chk("ready", 1'b0, packet_done_out);
        rx_pkt(32'hE7E7_E7E7, 1'b0, 1'b1);
        chk("match", 1'b0, addr_match_out);
        chk("ready", 1'b0, packet_done_out);
        rx_pkt(32'h1234_5678, 1'b1, 1'b0);
        chk("ready", 1'b0, packet_done_out);
        rx_pkt(32'hE7E7_E7E7, 1'b1, 1'b1);
        tx_select_pin <= 1'b1;
        wait_tx(1'b1);
        cyc(2);
        chk("ready", 1'b0, packet_done_out);
        chk("match", 1'b0, addr_match_out);
        chk("carrier", 1'b0, carrier_sense_out);
        for (int i = 0; i < PC + 64; i++) begin
            x = (i < PC) ? ~i[0] : TXD[31 - (i - PC) / 2] ^ i[0];
            chk("chip", x, tx_chip_out);
            cyc(CC);
        end
        wait_tx(1'b0);
        chk("ready", 1'b1, packet_done_out);
        cyc(20);
        chk("tx_on", 1'b0, tx_on_out);
        radio_activate <= 1'b0;
        cyc(1);
        radio_activate <= 1'b1;
        wait_tx(1'b1);
        cyc(1);
        chk("ready", 1'b0, packet_done_out);
        wait_tx(1'b0);
        chk("ready", 1'b1, packet_done_out);
        radio_activate <= 1'b0;
        tx_select_pin <= 1'b0;
        cyc(2);
        chk("ready", 1'b0, packet_done_out);
        rd(`RPSC_ADR_RXDAT, 32'h0, "rxdata");
        tx_select_pin <= 1'b1;
        apb(1'b1, `RPSC_ADR_CTRL, 32'h0000_0004);
        radio_activate <= 1'b1;
        pulses = 0;
        x = 1'b0;
        repeat (400) begin
            @(posedge pclk);
            if (packet_done_out === 1'b1 && x === 1'b0) pulses++;
            x = packet_done_out;
        end
        chk("pulses", 2, pulses);
        radio_activate <= 1'b0;
        cyc(4);
        chk("tx_on", 1'b1, tx_on_out);
        wait_tx(1'b0);
        tx_select_pin <= 1'b0;
        radio_activate <= 1'b1;
        cyc(2);
        rx_pkt(32'hE7E7_E7E7, 1'b1, 1'b1);
        power_on_in <= 1'b0;
        cyc(2);
        chk("ready", 1'b0, packet_done_out);
        chk("match", 1'b0, addr_match_out);
        // reset in mid-run while the resend bit is still set
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
        rd(`RPSC_ADR_CTRL, `RPSC_CTRL_RST, "ctrl");
        results();
    end
endmodule
